/* design/dssm_pkg.sv */
package dssm_pkg;
	localparam int clock_mhz = 20;
	// AHB register byte addresses
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_status = 8'h04;
	localparam logic [7:0] addr_mask = 8'h08;
	localparam logic [7:0] addr_state = 8'h0c;
	// Control field positions
	localparam int ctrl_failure_band_select_bit = 0;
	localparam int ctrl_digital_bit = 1;
	localparam int ctrl_rise_lsb = 2;
	localparam int ctrl_fall_lsb = 4;
	localparam int ctrl_deb_lsb = 6;
	localparam logic [8:0] ctrl_reset = 9'h000;
	localparam logic [4:0] mask_reset = 5'h00;
	// Readback timeouts, upper figure of each band in microseconds
	localparam int tmo1_us = 28;
	localparam int tmo2_us = 60;
	localparam int tmo3_us = 120;
	localparam int recheck_us = 120;
	localparam int cordic_ns = 111000;
	localparam int field_recovery_us = 1000;
	localparam int tmo1_cyc = tmo1_us * clock_mhz;
	localparam int tmo2_cyc = tmo2_us * clock_mhz;
	localparam int tmo3_cyc = tmo3_us * clock_mhz;
	localparam int recheck_cyc = recheck_us * clock_mhz;
	localparam int cordic_cyc = cordic_ns / 50;
	localparam int field_recovery_cyc = field_recovery_us * clock_mhz;
	// Status bit positions
	localparam int st_latched = 0;
	localparam int st_forced = 1;
	localparam int st_supply = 2;
	localparam int st_readback = 3;
	localparam int st_recovered = 4;
	typedef enum logic [3:0]
	{
		out_normal = 4'b0001,
		out_band = 4'b0010,
		out_hiz = 4'b0100,
		out_hiz_latched = 4'b1000
	} dssm_mode_e;
endpackage

/* design/dssm_fault_if.sv */
`timescale 1ns/100ps
interface dssm_fault_if;
	logic watchdog_fail;
	logic offset_incomplete;
	logic cordic_overflow;
	logic field_bad;
	logic supply_fault;
	logic adc_fail;
	logic signature_fail;
	modport src (output watchdog_fail, offset_incomplete, cordic_overflow, field_bad,
		supply_fault, adc_fail, signature_fail);
	modport dst (input watchdog_fail, offset_incomplete, cordic_overflow, field_bad,
		supply_fault, adc_fail, signature_fail);
endinterface

/* design/dssm_fault_sync.sv */
`timescale 1ns/100ps
module dssm_fault_sync
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [6:0] fault_pins,
	dssm_fault_if.src faults
);
	logic [6:0] stage1;
	logic [6:0] stage2;
	logic [31:0] field_count;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1 <= 7'h00;
			stage2 <= 7'h00;
		end
		else
		begin
			stage1 <= fault_pins;
			stage2 <= stage1;
		end
	end

	// Field fault stays asserted for the recovery time after the field returns
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			field_count <= 32'h0;
		else if (stage2[3])
			field_count <= 32'(dssm_pkg::field_recovery_cyc);
		else if (field_count != 32'h0)
			field_count <= field_count - 32'h1;
	end

	assign faults.watchdog_fail = stage2[0];
	assign faults.offset_incomplete = stage2[1];
	assign faults.cordic_overflow = stage2[2];
	assign faults.field_bad = stage2[3] || (field_count != 32'h0);
	assign faults.supply_fault = stage2[4];
	assign faults.adc_fail = stage2[5];
	assign faults.signature_fail = stage2[6];

	a_field_hold: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(stage2[3]) |-> faults.field_bad [*8])
		else $error("field fault released without recovery time");
endmodule

/* design/dssm_top.sv */
`timescale 1ns/100ps
module dssm_top
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [6:0] fault_pins,
	input wire logic readback_pin,
	input wire logic analog_mismatch,
	output logic out_drive_enable_n,
	output logic force_band,
	output logic band_upper,
	output logic irq
);
	logic rst_meta;
	logic reset_n;
	dssm_fault_if faults();
	dssm_pkg::dssm_mode_e mode;
	dssm_pkg::dssm_mode_e next_mode;
	logic [8:0] ctrl;
	logic [4:0] mask;
	logic [4:0] status;
	logic wr_pending;
	logic [7:0] wr_addr;
	logic rb_meta;
	logic rb_sync;
	logic rb_prev;
	logic mm_meta;
	logic mm_sync;
	logic [15:0] edge_count;
	logic edge_wait_rise;
	logic edge_wait_fall;
	logic [15:0] recheck_count;
	logic readback_err;
	logic [15:0] cordic_div;
	logic cordic_tick;
	logic [6:0] deb_count;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			reset_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			reset_n <= rst_meta;
		end
	end

	dssm_fault_sync u_sync
	(
		.clock(clock),
		.reset_n(reset_n),
		.fault_pins(fault_pins),
		.faults(faults.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Readback monitors

	function automatic logic [15:0] timeout_cycles(input logic [1:0] code);
		case (code)
			2'b01: timeout_cycles = 16'(dssm_pkg::tmo1_cyc);
			2'b10: timeout_cycles = 16'(dssm_pkg::tmo2_cyc);
			2'b11: timeout_cycles = 16'(dssm_pkg::tmo3_cyc);
			default: timeout_cycles = 16'h0;
		endcase
	endfunction

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
			rb_prev <= 1'b0;
			mm_meta <= 1'b0;
			mm_sync <= 1'b0;
		end
		else
		begin
			rb_meta <= readback_pin;
			rb_sync <= rb_meta;
			rb_prev <= rb_sync;
			mm_meta <= analog_mismatch;
			mm_sync <= mm_meta;
		end
	end

	wire digital_variant = ctrl[dssm_pkg::ctrl_digital_bit];
	wire [1:0] readback_rise_timeout_sel = ctrl[dssm_pkg::ctrl_rise_lsb +: 2];
	wire [1:0] readback_fall_timeout_sel = ctrl[dssm_pkg::ctrl_fall_lsb +: 2];
	wire [2:0] analog_readback_debounce = ctrl[dssm_pkg::ctrl_deb_lsb +: 3];
	wire rb_fell = rb_prev && !rb_sync;
	wire rb_rose = !rb_prev && rb_sync;
	wire rechecking = recheck_count != 16'h0;
	wire edge_limit = edge_wait_rise ? (edge_count >= timeout_cycles(readback_rise_timeout_sel))
		: (edge_count >= timeout_cycles(readback_fall_timeout_sel));
	wire edge_timeout = digital_variant && (edge_wait_rise || edge_wait_fall) && edge_limit;
	wire [6:0] deb_limit = (analog_readback_debounce == 3'h0) ? 7'h0
		: 7'(7'h1 << (analog_readback_debounce - 3'h1));
	wire analog_timeout = !digital_variant && (analog_readback_debounce != 3'h0)
		&& (deb_count >= deb_limit);

	// Edge watch: a falling edge must be followed by a rising one, and vice versa
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			edge_wait_rise <= 1'b0;
			edge_wait_fall <= 1'b0;
			edge_count <= 16'h0;
		end
		else if (edge_timeout || rechecking || !digital_variant)
		begin
			edge_wait_rise <= 1'b0;
			edge_wait_fall <= 1'b0;
			edge_count <= 16'h0;
		end
		else
		begin
			edge_wait_rise <= rb_fell ? (readback_rise_timeout_sel != 2'b00)
				: (edge_wait_rise && !rb_rose);
			edge_wait_fall <= rb_rose ? (readback_fall_timeout_sel != 2'b00)
				: (edge_wait_fall && !rb_fell);
			edge_count <= (rb_fell || rb_rose) ? 16'h0 : edge_count + 16'h1;
		end
	end

	// Angle cycle divider for the analog debounce
	assign cordic_tick = cordic_div == 16'(dssm_pkg::cordic_cyc - 1);
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			cordic_div <= 16'h0;
		else
			cordic_div <= cordic_tick ? 16'h0 : cordic_div + 16'h1;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			deb_count <= 7'h0;
		else if (!mm_sync || rechecking || digital_variant)
			deb_count <= 7'h0;
		else if (cordic_tick && deb_count != 7'h7f)
			deb_count <= deb_count + 7'h1;
	end

	// Hold hi-z for the recheck delay, then look again
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			recheck_count <= 16'h0;
		else if (edge_timeout || analog_timeout)
			recheck_count <= 16'(dssm_pkg::recheck_cyc);
		else if (rechecking)
			recheck_count <= recheck_count - 16'h1;
	end
	assign readback_err = rechecking;

	////////////////////////////////////////////////////////////////////////////////
	// Safe state selection

	wire latch_fault = faults.watchdog_fail || faults.adc_fail || faults.signature_fail;
	wire hiz_fault = faults.supply_fault || readback_err;
	wire band_fault = faults.offset_incomplete || faults.cordic_overflow || faults.field_bad;

	always_comb
	begin
		if (mode == dssm_pkg::out_hiz_latched || latch_fault)
			next_mode = dssm_pkg::out_hiz_latched;
		else if (hiz_fault)
			next_mode = dssm_pkg::out_hiz;
		else if (band_fault)
			next_mode = dssm_pkg::out_band;
		else
			next_mode = dssm_pkg::out_normal;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			mode <= dssm_pkg::out_normal;
		else
			mode <= next_mode;
	end

	always_comb
	begin
		case (mode)
			dssm_pkg::out_normal:
			begin
				out_drive_enable_n = 1'b0;
				force_band = 1'b0;
			end
			dssm_pkg::out_band:
			begin
				out_drive_enable_n = 1'b0;
				force_band = 1'b1;
			end
			default:
			begin
				out_drive_enable_n = 1'b1;
				force_band = 1'b0;
			end
		endcase
	end
	assign band_upper = ctrl[dssm_pkg::ctrl_failure_band_select_bit];

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	wire take = hsel && hready && htrans[1];
	wire rd_status = take && !hwrite && haddr[7:0] == dssm_pkg::addr_status;
	wire [3:0] events = {readback_err, faults.supply_fault, band_fault, latch_fault};
	// Recovery is flagged once, on the step back into normal output
	wire recovered_evt = mode != dssm_pkg::out_normal && next_mode == dssm_pkg::out_normal;
	wire [4:0] set_bits = {recovered_evt, events};

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
		end
		else
		begin
			wr_pending <= take && hwrite;
			wr_addr <= haddr[7:0];
			if (take && !hwrite)
				case (haddr[7:0])
					dssm_pkg::addr_ctrl: hrdata <= {23'h0, ctrl};
					dssm_pkg::addr_status: hrdata <= {27'h0, status};
					dssm_pkg::addr_mask: hrdata <= {27'h0, mask};
					dssm_pkg::addr_state: hrdata <= {28'h0, mode};
					default: hrdata <= 32'h0;
				endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl <= dssm_pkg::ctrl_reset;
			mask <= dssm_pkg::mask_reset;
		end
		else if (wr_pending && wr_addr == dssm_pkg::addr_ctrl)
			ctrl <= hwdata[8:0];
		else if (wr_pending && wr_addr == dssm_pkg::addr_mask)
			mask <= hwdata[4:0];
	end

	// Setting wins over the read that clears
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			status <= 5'h00;
		else
			status <= (rd_status ? 5'h00 : status) | set_bits;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(status & mask);

	a_latch_holds: assert property (@(posedge clock) disable iff (!reset_n)
		faults.watchdog_fail |=> (mode == dssm_pkg::out_hiz_latched) [*8])
		else $error("watchdog fault not latched");
	a_sig_latch: assert property (@(posedge clock) disable iff (!reset_n)
		$past(mode) == dssm_pkg::out_hiz_latched |-> mode == dssm_pkg::out_hiz_latched)
		else $error("latched hi-z released");
	a_offset_band: assert property (@(posedge clock) disable iff (!reset_n)
		(faults.offset_incomplete && !latch_fault && !hiz_fault && mode != dssm_pkg::out_hiz_latched)
		|=> force_band)
		else $error("offset fault not forcing band");
	a_cordic_band: assert property (@(posedge clock) disable iff (!reset_n)
		(faults.cordic_overflow && !latch_fault && !hiz_fault && mode != dssm_pkg::out_hiz_latched)
		|=> force_band && !out_drive_enable_n)
		else $error("overflow not forcing band");
	a_supply_hiz: assert property (@(posedge clock) disable iff (!reset_n)
		faults.supply_fault |=> out_drive_enable_n && !force_band)
		else $error("supply fault not hi-z");
	a_supply_free: assert property (@(posedge clock) disable iff (!reset_n)
		(mode == dssm_pkg::out_hiz && !latch_fault && !hiz_fault && !band_fault)
		|=> mode == dssm_pkg::out_normal)
		else $error("supply fault not released");
	a_edge_hiz: assert property (@(posedge clock) disable iff (!reset_n)
		edge_timeout |-> ##2 out_drive_enable_n [*2])
		else $error("missing edge not hi-z");
	a_rise_limit: assert property (@(posedge clock) disable iff (!reset_n)
		(digital_variant && edge_wait_rise && readback_rise_timeout_sel == 2'b01 && !rechecking
		&& edge_count == 16'(dssm_pkg::tmo1_cyc)) |=> rechecking)
		else $error("rise timeout wrong");
	a_analog_hiz: assert property (@(posedge clock) disable iff (!reset_n)
		analog_timeout |=> recheck_count == 16'(dssm_pkg::recheck_cyc))
		else $error("analog mismatch not caught");
endmodule

/* verification/dssm_ecu_model.sv */
`timescale 1ns/100ps
module dssm_ecu_model
(
	input wire logic clock,
	input wire logic out_drive_enable_n,
	input wire logic force_band,
	input wire logic band_upper,
	input wire logic [11:0] half,
	input wire logic stop_level,
	input wire logic mism_cmd,
	output logic readback_pin,
	output logic analog_mismatch
);
	logic level = 1'b0;
	logic [11:0] cnt = 12'h000;
	logic wrap;
	assign wrap = cnt == half - 12'h001;
	// Zero half period holds the line at stop_level, a stuck output for the monitor
	always @(posedge clock)
	begin
		cnt <= (half == 12'h000 || wrap) ? 12'h000 : cnt + 12'h001;
		level <= (half == 12'h000) ? stop_level : level ^ wrap;
	end
	// Released line sinks to the pull-down, never shows the last level
	assign readback_pin = ~out_drive_enable_n & (force_band ? band_upper : level);
	assign analog_mismatch = mism_cmd;
endmodule

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [6:0] pins = 7'h00;
	logic hreadyout, hresp, en_n, force_band, band_upper, irq, rb, am;
	logic stop_lv = 1'b0, mism = 1'b0;
	logic [11:0] half = 12'h000;
	int num_errors = 0, cmp_count = 0, cyc = 0, n, t, k;
	typedef struct packed
	{
		logic [8:0] ctrl;
		logic [6:0] pins;
		logic [3:0] on;
		logic [3:0] off;
	} dssm_row_s;
	dssm_row_s rows [9] = '{'{9'h000, 7'h01, 4'h8, 4'h8}, '{9'h000, 7'h02, 4'h2, 4'h1},
		'{9'h001, 7'h04, 4'h2, 4'h1}, '{9'h000, 7'h08, 4'h2, 4'h2},
		'{9'h000, 7'h10, 4'h4, 4'h1}, '{9'h000, 7'h20, 4'h8, 4'h8},
		'{9'h000, 7'h40, 4'h8, 4'h8}, '{9'h001, 7'h12, 4'h4, 4'h1},
		'{9'h000, 7'h11, 4'h8, 4'h8}};
	int pctl [5] = '{2, 6, 10, 14, 18};
	int ptm [5] = '{3000, dssm_pkg::tmo1_cyc, dssm_pkg::tmo2_cyc, dssm_pkg::tmo3_cyc,
		dssm_pkg::tmo1_cyc};
	dssm_top dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_pins(pins),
		.readback_pin(rb), .analog_mismatch(am), .out_drive_enable_n(en_n),
		.force_band(force_band), .band_upper(band_upper), .irq(irq));
	dssm_ecu_model ecu (.clock(clock), .out_drive_enable_n(en_n), .force_band(force_band),
		.band_upper(band_upper), .half(half), .stop_level(stop_lv), .mism_cmd(mism),
		.readback_pin(rb), .analog_mismatch(am));
	initial forever #25 clock = ~clock;
	task check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
		check({30'h0, hresp, hreadyout}, 32'h1);
	endtask
	task do_reset;
		@(posedge clock);
		rstn <= 1'b0;
		pins <= 7'h00;
		repeat (3) @(posedge clock);
		check({27'h0, en_n, force_band, irq, band_upper, |hrdata}, 32'h0);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	// Bounded poll: n returns lim if the driver never let go
	task wait_hiz(input int lim);
		n = 0;
		while (en_n !== 1'b1 && n < lim)
		begin
			@(posedge clock);
			n++;
		end
	endtask
	task results;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc > 90000)
		begin
			num_errors++;
			results;
		end
	end
	initial
	begin
		foreach (rows[i])
		begin
			do_reset;
			ahb(1'b1, dssm_pkg::addr_ctrl, {23'h0, rows[i].ctrl});
			pins <= rows[i].pins;
			repeat (8) @(posedge clock);
			ahb(1'b0, dssm_pkg::addr_state, 32'h0);
			check(rd, {28'h0, rows[i].on});
			check({31'h0, en_n}, {31'h0, rows[i].on[2] | rows[i].on[3]});
			check({31'h0, force_band}, {31'h0, rows[i].on[1]});
			check({31'h0, band_upper}, {31'h0, rows[i].ctrl[0]});
			pins <= 7'h00;
			repeat (8) @(posedge clock);
			ahb(1'b0, dssm_pkg::addr_state, 32'h0);
			check(rd, {28'h0, rows[i].off});
		end
		$display("table done");
		do_reset;
		ahb(1'b1, dssm_pkg::addr_mask, 32'h4);
		pins <= 7'h10;
		repeat (8) @(posedge clock);
		check({31'h0, irq}, 32'h1);
		ahb(1'b0, dssm_pkg::addr_status, 32'h0);
		check(rd & 32'h4, 32'h4);
		pins <= 7'h00;
		repeat (8) @(posedge clock);
		ahb(1'b0, dssm_pkg::addr_status, 32'h0);
		ahb(1'b0, dssm_pkg::addr_status, 32'h0);
		check({rd[30:0], irq}, 32'h0);
		ahb(1'b1, dssm_pkg::addr_mask, 32'h0);
		pins <= 7'h02;
		repeat (8) @(posedge clock);
		check({31'h0, irq}, 32'h0);
		ahb(1'b0, dssm_pkg::addr_status, 32'h0);
		check(rd & 32'h2, 32'h2);
		ahb(1'b1, 8'h10, 32'hffffffff);
		ahb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		ahb(1'b1, dssm_pkg::addr_ctrl, 32'h1ff);
		ahb(1'b0, dssm_pkg::addr_ctrl, 32'h0);
		check(rd, 32'h1ff);
		$display("registers done");
		do_reset;
		pins <= 7'h08;
		repeat (8) @(posedge clock);
		pins <= 7'h00;
		repeat (dssm_pkg::field_recovery_cyc - 100) @(posedge clock);
		ahb(1'b0, dssm_pkg::addr_state, 32'h0);
		check(rd, 32'h2);
		repeat (200) @(posedge clock);
		ahb(1'b0, dssm_pkg::addr_state, 32'h0);
		check(rd, 32'h1);
		$display("field recovery done");
		half <= 12'h014;
		for (int i = 0; i < 5; i++)
		begin
			ahb(1'b1, dssm_pkg::addr_ctrl, 32'(pctl[i]));
			repeat (3000) @(posedge clock);
			t = ptm[i];
			half <= 12'h000;
			stop_lv <= i == 4;
			wait_hiz(t + 30);
			check({31'h0, i ? n >= t - 5 && n <= t + 30 : n == t + 30}, 32'h1);
			half <= 12'h014;
			repeat (3000) @(posedge clock);
			check({31'h0, en_n}, 32'h0);
		end
		$display("pulse readback done");
		half <= 12'h000;
		for (int c = 0; c < 4; c++)
		begin
			ahb(1'b1, dssm_pkg::addr_ctrl, 32'(c) << 6);
			mism <= 1'b1;
			k = c ? 1 << (c - 1) : 0;
			t = c ? (k + 1) * dssm_pkg::cordic_cyc + 10 : 3000;
			wait_hiz(t);
			check({31'h0, c ? n >= (k - 1) * dssm_pkg::cordic_cyc : n == t}, 32'h1);
			check({31'h0, n <= t}, 32'h1);
			mism <= 1'b0;
			repeat (2600) @(posedge clock);
			check({31'h0, en_n}, 32'h0);
		end
		$display("analog readback done");
		results;
	end
endmodule
